// ==== hdl/fcsm_pkg.sv ====
// Purpose: shared constants and state codes of the flash command decoder
// Assumes: one command byte per host write cycle
// Notes: command codes outside the decoded set leave idle states unchanged
package fcsm_pkg;
  // ****************************************************************
  // command codes
  // ****************************************************************
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] CMD_PROG_SETUP_A = 8'h10;
  localparam logic [7:0] CMD_PROG_SETUP_B = 8'h40;
  localparam logic [7:0] CMD_WBUF_SETUP = 8'hE8;
  localparam logic [7:0] CMD_FACTORY_SETUP = 8'h30;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] CMD_CONFIRM = 8'hD0;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_LOCK_CODE_A = 8'h01;
  localparam logic [7:0] CMD_LOCK_CODE_B = 8'h2F;
  localparam logic [7:0] CMD_LOCK_CODE_C = 8'h03;
  // plain defaults for codes not fixed by this block's table
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_READ_CONFIG = 8'h90;
  localparam logic [7:0] CMD_READ_QUERY = 8'h98;
  localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
  localparam logic [7:0] CMD_OTP_SETUP = 8'hC0;

  // ****************************************************************
  // read source select
  // ****************************************************************
  localparam logic [1:0] RD_ARRAY = 2'h0;
  localparam logic [1:0] RD_STATUS = 2'h1;
  localparam logic [1:0] RD_CONFIG = 2'h2;
  localparam logic [1:0] RD_QUERY = 2'h3;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int PROG_TIME_NS = 20000;
  localparam int PROG_CYCLES_INT =
    (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W = 12;
  localparam logic [TIMER_W-1:0] PROG_CYCLES = PROG_CYCLES_INT[TIMER_W-1:0];

  // ****************************************************************
  // states
  // ****************************************************************
  typedef enum logic [4:0] {
    S_RA = 5'h00, S_RS = 5'h01, S_RC = 5'h02, S_RQ = 5'h03,
    S_LOCK = 5'h04, S_LOCK_ES = 5'h05,
    S_BOTCH = 5'h06, S_BOTCH_ES = 5'h07, S_BOTCH_PS = 5'h08,
    S_BOTCH_BS = 5'h09,
    S_OTP_SETUP = 5'h0A, S_OTP_BUSY = 5'h0B, S_OTP_DONE = 5'h0C,
    S_PRG_SETUP = 5'h0D, S_PRG_SETUP_ES = 5'h0E,
    S_PRG_BUSY = 5'h0F, S_PRG_BUSY_ES = 5'h10,
    S_RS_PS = 5'h11, S_RA_PS = 5'h12, S_RC_PS = 5'h13, S_RQ_PS = 5'h14,
    S_RA_ES = 5'h15, S_RS_ES = 5'h16, S_RA_BS = 5'h17, S_RS_BS = 5'h18,
    S_WBUF = 5'h19, S_FACTORY = 5'h1A, S_ERS_SETUP = 5'h1B,
    S_ERS_BUSY = 5'h1C
  } fcsm_state_type;
endpackage

// ==== hdl/fcsm_prog_timer.sv ====
// Purpose: programming time counter shared by array and one-time area
// Assumes: start and run never overlap in one cycle
// Notes: count pauses while run is low, so a suspend keeps the remainder
`timescale 1ns/1ps
module fcsm_prog_timer (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic run,
  output logic done
);
  logic [fcsm_pkg::TIMER_W-1:0] cnt_reg;
  logic [fcsm_pkg::TIMER_W-1:0] cnt_next;
  logic [fcsm_pkg::TIMER_W-1:0] one;

  assign one = {{(fcsm_pkg::TIMER_W-1){1'b0}}, 1'b1};
  assign cnt_next = start ? fcsm_pkg::PROG_CYCLES :
                    (run && cnt_reg != '0) ? cnt_reg - one : cnt_reg;
  // decoded in the last count cycle, so done and a suspend meet in one
  // cycle; a registered done could strand a suspended count at zero
  assign done = run && !start && cnt_reg == one;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
endmodule

// ==== hdl/fcsm_top.sv ====
// Purpose: command decoder for lock, error, one-time area and program paths
// Assumes: host writes arrive as cmdValid pulses on ref_clk
// Notes: buffer and factory paths wait for extDone; erase takes confirm
//
// Contract
// - bad lock second cycle enters matching error
// - error state reads status, E8 stays there
// - one-time area data write starts busy programming
// - one-time area done: ready, status, idle commands
`timescale 1ns/1ps
module fcsm_top (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic cmdValid,
  input wire logic [7:0] cmdData,
  input wire logic extDone,
  output logic wsmReadyFlag,
  output logic [1:0] readSel,
  output logic cmdSeqError,
  output logic progStart,
  output logic otpProg,
  output logic [7:0] progData,
  output logic lockStrobe,
  output logic [7:0] lockCode,
  output fcsm_pkg::fcsm_state_type state
);
  // ****************************************************************
  // next state decode
  // ****************************************************************
  fcsm_pkg::fcsm_state_type state_reg;
  fcsm_pkg::fcsm_state_type state_next;
  logic progDone;
  logic lockOk;
  logic isProgCmd;
  logic busyNext;
  logic runTimer;
  logic [1:0] readSel_next;
  logic errNext;
  logic startNext;
  logic lockNext;
  assign state = state_reg;
  assign lockOk = cmdData == fcsm_pkg::CMD_CONFIRM ||
                  cmdData == fcsm_pkg::CMD_LOCK_CODE_A ||
                  cmdData == fcsm_pkg::CMD_LOCK_CODE_B ||
                  cmdData == fcsm_pkg::CMD_LOCK_CODE_C;
  assign isProgCmd = cmdData == fcsm_pkg::CMD_PROG_SETUP_A ||
                     cmdData == fcsm_pkg::CMD_PROG_SETUP_B;
  // idle read states, the plain error state and one-time area done
  function automatic fcsm_pkg::fcsm_state_type idleNext(
    input logic [7:0] c, input fcsm_pkg::fcsm_state_type cur);
    fcsm_pkg::fcsm_state_type n;
    n = cur;
    case (c)
      fcsm_pkg::CMD_READ_ARRAY: n = fcsm_pkg::S_RA;
      fcsm_pkg::CMD_PROG_SETUP_A: n = fcsm_pkg::S_PRG_SETUP;
      fcsm_pkg::CMD_PROG_SETUP_B: n = fcsm_pkg::S_PRG_SETUP;
      fcsm_pkg::CMD_WBUF_SETUP: n = fcsm_pkg::S_WBUF;
      fcsm_pkg::CMD_FACTORY_SETUP: n = fcsm_pkg::S_FACTORY;
      fcsm_pkg::CMD_ERASE_SETUP: n = fcsm_pkg::S_ERS_SETUP;
      fcsm_pkg::CMD_CONFIRM: n = fcsm_pkg::S_RA;
      fcsm_pkg::CMD_SUSPEND: n = fcsm_pkg::S_RS;
      fcsm_pkg::CMD_READ_STATUS: n = fcsm_pkg::S_RS;
      fcsm_pkg::CMD_READ_CONFIG: n = fcsm_pkg::S_RC;
      fcsm_pkg::CMD_READ_QUERY: n = fcsm_pkg::S_RQ;
      fcsm_pkg::CMD_LOCK_SETUP: n = fcsm_pkg::S_LOCK;
      fcsm_pkg::CMD_OTP_SETUP: n = fcsm_pkg::S_OTP_SETUP;
      default: n = cur;
    endcase
    return n;
  endfunction
  // reads while a program is suspended; confirm resumes it
  function automatic fcsm_pkg::fcsm_state_type progSuspNext(
    input logic [7:0] c, input fcsm_pkg::fcsm_state_type wbufDest);
    fcsm_pkg::fcsm_state_type n;
    n = fcsm_pkg::S_RA_PS;
    case (c)
      fcsm_pkg::CMD_WBUF_SETUP: n = wbufDest;
      fcsm_pkg::CMD_CONFIRM: n = fcsm_pkg::S_PRG_BUSY;
      fcsm_pkg::CMD_SUSPEND: n = fcsm_pkg::S_RS_PS;
      fcsm_pkg::CMD_READ_STATUS: n = fcsm_pkg::S_RS_PS;
      fcsm_pkg::CMD_READ_CONFIG: n = fcsm_pkg::S_RC_PS;
      fcsm_pkg::CMD_READ_QUERY: n = fcsm_pkg::S_RQ_PS;
      default: n = fcsm_pkg::S_RA_PS;
    endcase
    return n;
  endfunction
  // reads while an erase is suspended
  function automatic fcsm_pkg::fcsm_state_type ersSuspNext(
    input logic [7:0] c, input fcsm_pkg::fcsm_state_type wbufDest);
    fcsm_pkg::fcsm_state_type n;
    n = fcsm_pkg::S_RA_ES;
    case (c)
      fcsm_pkg::CMD_PROG_SETUP_A: n = fcsm_pkg::S_PRG_SETUP_ES;
      fcsm_pkg::CMD_PROG_SETUP_B: n = fcsm_pkg::S_PRG_SETUP_ES;
      fcsm_pkg::CMD_WBUF_SETUP: n = wbufDest;
      fcsm_pkg::CMD_FACTORY_SETUP: n = fcsm_pkg::S_RS_ES;
      fcsm_pkg::CMD_CONFIRM: n = fcsm_pkg::S_ERS_BUSY;
      fcsm_pkg::CMD_SUSPEND: n = fcsm_pkg::S_RS_ES;
      fcsm_pkg::CMD_READ_STATUS: n = fcsm_pkg::S_RS_ES;
      fcsm_pkg::CMD_LOCK_SETUP: n = fcsm_pkg::S_LOCK_ES;
      default: n = fcsm_pkg::S_RA_ES;
    endcase
    return n;
  endfunction
  // reads with both a program and an erase suspended
  function automatic fcsm_pkg::fcsm_state_type bothSuspNext(
    input logic [7:0] c, input fcsm_pkg::fcsm_state_type wbufDest);
    fcsm_pkg::fcsm_state_type n;
    n = fcsm_pkg::S_RA_BS;
    case (c)
      fcsm_pkg::CMD_WBUF_SETUP: n = wbufDest;
      fcsm_pkg::CMD_CONFIRM: n = fcsm_pkg::S_PRG_BUSY_ES;
      fcsm_pkg::CMD_SUSPEND: n = fcsm_pkg::S_RS_BS;
      fcsm_pkg::CMD_READ_STATUS: n = fcsm_pkg::S_RS_BS;
      default: n = fcsm_pkg::S_RA_BS;
    endcase
    return n;
  endfunction
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      fcsm_pkg::S_RA, fcsm_pkg::S_RS, fcsm_pkg::S_RC, fcsm_pkg::S_RQ,
      fcsm_pkg::S_OTP_DONE: begin
        if (cmdValid) state_next = idleNext(cmdData, state_reg);
      end
      fcsm_pkg::S_BOTCH: begin
        if (cmdValid && cmdData != fcsm_pkg::CMD_WBUF_SETUP) begin
          state_next = idleNext(cmdData, state_reg);
        end
      end
      fcsm_pkg::S_LOCK: begin
        if (cmdValid) begin
          state_next = lockOk ? fcsm_pkg::S_RS : fcsm_pkg::S_BOTCH;
        end
      end
      fcsm_pkg::S_LOCK_ES: begin
        if (cmdValid) begin
          state_next = lockOk ? fcsm_pkg::S_RS_ES : fcsm_pkg::S_BOTCH_ES;
        end
      end
      fcsm_pkg::S_BOTCH_ES, fcsm_pkg::S_RA_ES, fcsm_pkg::S_RS_ES: begin
        if (cmdValid) begin
          state_next = ersSuspNext(cmdData, fcsm_pkg::S_BOTCH_ES);
        end
      end
      fcsm_pkg::S_BOTCH_PS, fcsm_pkg::S_RS_PS, fcsm_pkg::S_RA_PS,
      fcsm_pkg::S_RC_PS, fcsm_pkg::S_RQ_PS: begin
        if (cmdValid) begin
          state_next = progSuspNext(cmdData,
            state_reg == fcsm_pkg::S_BOTCH_PS ? state_reg :
            fcsm_pkg::S_RA_PS);
        end
      end
      fcsm_pkg::S_BOTCH_BS, fcsm_pkg::S_RA_BS, fcsm_pkg::S_RS_BS: begin
        if (cmdValid) begin
          state_next = bothSuspNext(cmdData, fcsm_pkg::S_BOTCH_BS);
        end
      end
      fcsm_pkg::S_OTP_SETUP: begin
        if (cmdValid) state_next = fcsm_pkg::S_OTP_BUSY;
      end
      fcsm_pkg::S_OTP_BUSY: begin
        // further writes are ignored until the cell program ends
        if (progDone) state_next = fcsm_pkg::S_OTP_DONE;
      end
      fcsm_pkg::S_PRG_SETUP: begin
        if (cmdValid) state_next = fcsm_pkg::S_PRG_BUSY;
      end
      fcsm_pkg::S_PRG_SETUP_ES: begin
        if (cmdValid) state_next = fcsm_pkg::S_PRG_BUSY_ES;
      end
      fcsm_pkg::S_PRG_BUSY: begin
        // done wins over a suspend written in the same cycle
        if (progDone) begin
          state_next = fcsm_pkg::S_RS;
        end else if (cmdValid && cmdData == fcsm_pkg::CMD_SUSPEND) begin
          state_next = fcsm_pkg::S_RS_PS;
        end
      end
      fcsm_pkg::S_PRG_BUSY_ES: begin
        if (progDone) begin
          state_next = fcsm_pkg::S_RS_ES;
        end else if (cmdValid && cmdData == fcsm_pkg::CMD_SUSPEND) begin
          state_next = fcsm_pkg::S_RS_BS;
        end
      end
      fcsm_pkg::S_ERS_BUSY: begin
        if (extDone) begin
          state_next = fcsm_pkg::S_RS;
        end else if (cmdValid && cmdData == fcsm_pkg::CMD_SUSPEND) begin
          state_next = fcsm_pkg::S_RS_ES;
        end
      end
      fcsm_pkg::S_WBUF, fcsm_pkg::S_FACTORY: begin
        if (extDone) state_next = fcsm_pkg::S_RS;
      end
      fcsm_pkg::S_ERS_SETUP: begin
        if (cmdValid && cmdData == fcsm_pkg::CMD_CONFIRM) begin
          state_next = fcsm_pkg::S_ERS_BUSY;
        end else if (extDone) state_next = fcsm_pkg::S_RS;
      end
      default: state_next = fcsm_pkg::S_RA;
    endcase
  end
  // ****************************************************************
  // output decode
  // ****************************************************************
  assign busyNext = state_next == fcsm_pkg::S_OTP_BUSY ||
                    state_next == fcsm_pkg::S_PRG_BUSY ||
                    state_next == fcsm_pkg::S_PRG_BUSY_ES ||
                    state_next == fcsm_pkg::S_ERS_BUSY;
  assign runTimer = state_reg == fcsm_pkg::S_OTP_BUSY ||
                    state_reg == fcsm_pkg::S_PRG_BUSY ||
                    state_reg == fcsm_pkg::S_PRG_BUSY_ES;
  assign startNext = cmdValid && (state_reg == fcsm_pkg::S_OTP_SETUP ||
                     state_reg == fcsm_pkg::S_PRG_SETUP ||
                     state_reg == fcsm_pkg::S_PRG_SETUP_ES);
  assign lockNext = cmdValid && lockOk &&
                    (state_reg == fcsm_pkg::S_LOCK ||
                     state_reg == fcsm_pkg::S_LOCK_ES);
  assign errNext = state_next == fcsm_pkg::S_BOTCH ||
                   state_next == fcsm_pkg::S_BOTCH_ES ||
                   state_next == fcsm_pkg::S_BOTCH_PS ||
                   state_next == fcsm_pkg::S_BOTCH_BS;
  // only the array read states, S_WBUF, config and query states leave status
  assign readSel_next =
    (state_next == fcsm_pkg::S_RA || state_next == fcsm_pkg::S_RA_PS ||
     state_next == fcsm_pkg::S_RA_ES || state_next == fcsm_pkg::S_RA_BS ||
     state_next == fcsm_pkg::S_WBUF) ? fcsm_pkg::RD_ARRAY :
    (state_next == fcsm_pkg::S_RC || state_next == fcsm_pkg::S_RC_PS) ?
      fcsm_pkg::RD_CONFIG :
    (state_next == fcsm_pkg::S_RQ || state_next == fcsm_pkg::S_RQ_PS) ?
      fcsm_pkg::RD_QUERY : fcsm_pkg::RD_STATUS;
  fcsm_prog_timer progTimer (
    .ref_clk(ref_clk),
    .rst(rst),
    .start(startNext),
    .run(runTimer),
    .done(progDone)
  );
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg <= fcsm_pkg::S_RA;
      wsmReadyFlag <= 1'b1;
      readSel <= fcsm_pkg::RD_ARRAY;
      cmdSeqError <= 1'b0;
      progStart <= 1'b0;
      otpProg <= 1'b0;
      progData <= 8'h00;
      lockStrobe <= 1'b0;
      lockCode <= 8'h00;
    end else begin
      state_reg <= state_next;
      wsmReadyFlag <= !busyNext;
      readSel <= readSel_next;
      cmdSeqError <= errNext;
      progStart <= startNext;
      if (startNext) otpProg <= state_reg == fcsm_pkg::S_OTP_SETUP;
      if (startNext) progData <= cmdData;
      lockStrobe <= lockNext;
      if (lockNext) lockCode <= cmdData;
    end
  end
  // ****************************************************************
  // checks
  // ****************************************************************
  a_lock_bad_code: assert property (@(posedge ref_clk) disable iff (rst)
    state_reg == fcsm_pkg::S_LOCK && cmdValid && !lockOk |=>
      state_reg == fcsm_pkg::S_BOTCH && cmdSeqError)
    else $error("bad lock code did not enter error state");
  a_lock_bad_esusp: assert property (@(posedge ref_clk) disable iff (rst)
    state_reg == fcsm_pkg::S_LOCK_ES && cmdValid && !lockOk |=>
      state_reg == fcsm_pkg::S_BOTCH_ES)
    else $error("bad lock code in erase suspend not flagged");
  a_error_reads_status: assert property (@(posedge ref_clk)
    disable iff (rst) cmdSeqError |-> readSel == fcsm_pkg::RD_STATUS)
    else $error("error state does not read status");
  a_error_wbuf_stays: assert property (@(posedge ref_clk)
    disable iff (rst) state_reg == fcsm_pkg::S_BOTCH && cmdValid &&
      cmdData == fcsm_pkg::CMD_WBUF_SETUP |=> state_reg == fcsm_pkg::S_BOTCH)
    else $error("buffer setup left the error state");
  a_otp_busy_hold: assert property (@(posedge ref_clk) disable iff (rst)
    state_reg == fcsm_pkg::S_OTP_SETUP && cmdValid |=>
      (!wsmReadyFlag && state_reg == fcsm_pkg::S_OTP_BUSY) [*8])
    else $error("one-time area program not held busy");
  a_otp_done_ready: assert property (@(posedge ref_clk) disable iff (rst)
    state_reg == fcsm_pkg::S_OTP_BUSY && progDone |=>
      wsmReadyFlag && readSel == fcsm_pkg::RD_STATUS &&
      state_reg == fcsm_pkg::S_OTP_DONE)
    else $error("one-time area completion not reported");
  a_otp_done_accepts: assert property (@(posedge ref_clk)
    disable iff (rst) state_reg == fcsm_pkg::S_OTP_DONE && cmdValid &&
      isProgCmd |=> state_reg == fcsm_pkg::S_PRG_SETUP)
    else $error("program setup refused after completion");
  a_ready_tracks_busy: assert property (@(posedge ref_clk)
    disable iff (rst) wsmReadyFlag == !(runTimer || state_reg ==
      fcsm_pkg::S_ERS_BUSY)) else $error("ready flag disagrees with busy");
endmodule

// ==== verif/fcsm_host_model.sv ====
// Purpose: host side that writes command and data bytes to the decoder
// Assumes: one byte per write cycle, strobe high for one ref_clk cycle
// Notes: after a write the data lines carry the inverted byte, never stale
`timescale 1ns/1ps
module fcsm_host_model (
  input wire logic ref_clk,
  output logic cmdValid,
  output logic [7:0] cmdData
);
  initial begin
    cmdValid = 1'b0;
    cmdData = 8'h00;
  end

  // ****************************************************************
  // write cycle
  // ****************************************************************
  // returns 1 ns after the taking edge, so outputs are settled for checks
  task automatic send(input logic [7:0] b);
    @(posedge ref_clk);
    cmdValid <= 1'b1;
    cmdData <= b;
    @(posedge ref_clk);
    cmdValid <= 1'b0;
    cmdData <= ~b;
    #1;
  endtask
endmodule

// ==== verif/fcsm_top_tb.sv ====
// Purpose: self-checking bench for the lock, error, otp and program paths
// Assumes: extDone stays low; erase is only confirmed and suspended
// Notes: each scenario starts from a fresh reset
`timescale 1ns/1ps
`define FCSM_CHK(nm, exp, got) \
  begin \
    compares++; \
    if ((got) !== (exp)) begin \
      errors++; \
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, got); \
    end \
  end
module fcsm_top_tb;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic extDone = 1'b0;
  logic cmdValid;
  logic [7:0] cmdData;
  logic wsmReadyFlag;
  logic [1:0] readSel;
  logic cmdSeqError;
  logic progStart;
  logic otpProg;
  logic [7:0] progData;
  logic lockStrobe;
  logic [7:0] lockCode;
  fcsm_pkg::fcsm_state_type state;
  int errors = 0;
  int compares = 0;
  int cycles = 0;

  always #50 ref_clk = ~ref_clk;

  fcsm_host_model i_host (.ref_clk(ref_clk), .cmdValid(cmdValid),
    .cmdData(cmdData));

  fcsm_top i_dut (.ref_clk(ref_clk), .rst(rst), .cmdValid(cmdValid),
    .cmdData(cmdData), .extDone(extDone), .wsmReadyFlag(wsmReadyFlag),
    .readSel(readSel), .cmdSeqError(cmdSeqError), .progStart(progStart),
    .otpProg(otpProg), .progData(progData), .lockStrobe(lockStrobe),
    .lockCode(lockCode), .state(state));

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic summarize();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // hang guard: all scenarios need about 2000 cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      summarize();
    end
  end

  task automatic do_reset();
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    #1;
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    while (wsmReadyFlag !== 1'b1 && n < 400) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    `FCSM_CHK("ready wait bounded", 1'b1, n < 400)
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_lock();
    logic [7:0] good [4] = '{8'hD0, 8'h01, 8'h2F, 8'h03};
    logic [7:0] bad [4] = '{8'h55, 8'hFF, 8'h02, 8'hD1};
    logic [7:0] nxt [4] = '{8'hFF, 8'h70, 8'h20, 8'h30};
    fcsm_pkg::fcsm_state_type exp [4] = '{fcsm_pkg::S_RA, fcsm_pkg::S_RS,
      fcsm_pkg::S_ERS_SETUP, fcsm_pkg::S_FACTORY};
    do_reset();
    `FCSM_CHK("ready at reset", 1'b1, wsmReadyFlag)
    for (int i = 0; i < 4; i++) begin
      i_host.send(fcsm_pkg::CMD_LOCK_SETUP);
      `FCSM_CHK("lock setup state", fcsm_pkg::S_LOCK, state)
      `FCSM_CHK("ready in lock setup", 1'b1, wsmReadyFlag)
      i_host.send(good[i]);
      `FCSM_CHK("lock strobe", 1'b1, lockStrobe)
      `FCSM_CHK("lock code", good[i], lockCode)
      `FCSM_CHK("no error good code", 1'b0, cmdSeqError)
    end
    for (int i = 0; i < 4; i++) begin
      do_reset();
      i_host.send(fcsm_pkg::CMD_LOCK_SETUP);
      i_host.send(bad[i]);
      `FCSM_CHK("error state", fcsm_pkg::S_BOTCH, state)
      `FCSM_CHK("error flag", 1'b1, cmdSeqError)
      `FCSM_CHK("no lock strobe", 1'b0, lockStrobe)
      `FCSM_CHK("error reads status", fcsm_pkg::RD_STATUS, readSel)
      `FCSM_CHK("ready in error", 1'b1, wsmReadyFlag)
      i_host.send(fcsm_pkg::CMD_WBUF_SETUP);
      `FCSM_CHK("buffer setup keeps error", fcsm_pkg::S_BOTCH, state)
      i_host.send(nxt[i]);
      `FCSM_CHK("error leaves as idle", exp[i], state)
    end
    // lock and error paths with an erase suspended
    do_reset();
    i_host.send(fcsm_pkg::CMD_ERASE_SETUP);
    i_host.send(fcsm_pkg::CMD_CONFIRM);
    `FCSM_CHK("erase busy flag", 1'b0, wsmReadyFlag)
    i_host.send(fcsm_pkg::CMD_SUSPEND);
    `FCSM_CHK("erase suspended ready", 1'b1, wsmReadyFlag)
    i_host.send(fcsm_pkg::CMD_LOCK_SETUP);
    `FCSM_CHK("lock setup esusp", fcsm_pkg::S_LOCK_ES, state)
    i_host.send(8'h55);
    `FCSM_CHK("esusp error state", fcsm_pkg::S_BOTCH_ES, state)
    `FCSM_CHK("esusp error flag", 1'b1, cmdSeqError)
    `FCSM_CHK("esusp error status", fcsm_pkg::RD_STATUS, readSel)
    i_host.send(fcsm_pkg::CMD_WBUF_SETUP);
    `FCSM_CHK("esusp wbuf keeps error", fcsm_pkg::S_BOTCH_ES, state)
    i_host.send(fcsm_pkg::CMD_READ_ARRAY);
    `FCSM_CHK("esusp error leaves", fcsm_pkg::S_RA_ES, state)
    i_host.send(fcsm_pkg::CMD_LOCK_SETUP);
    i_host.send(8'h01);
    `FCSM_CHK("esusp good lock", fcsm_pkg::S_RS_ES, state)
    `FCSM_CHK("esusp lock strobe", 1'b1, lockStrobe)
    $display("test lock done");
  endtask

  task automatic t_otp();
    logic [7:0] nxt [7] = '{8'h10, 8'h40, 8'hE8, 8'h30, 8'h20, 8'hFF, 8'h70};
    fcsm_pkg::fcsm_state_type exp [7] = '{fcsm_pkg::S_PRG_SETUP,
      fcsm_pkg::S_PRG_SETUP, fcsm_pkg::S_WBUF, fcsm_pkg::S_FACTORY,
      fcsm_pkg::S_ERS_SETUP, fcsm_pkg::S_RA, fcsm_pkg::S_RS};
    for (int i = 0; i < 7; i++) begin
      do_reset();
      i_host.send(fcsm_pkg::CMD_OTP_SETUP);
      `FCSM_CHK("otp setup state", fcsm_pkg::S_OTP_SETUP, state)
      i_host.send(8'hA5 ^ 8'(i));
      `FCSM_CHK("otp start pulse", 1'b1, progStart)
      `FCSM_CHK("otp kind", 1'b1, otpProg)
      `FCSM_CHK("otp data", 8'hA5 ^ 8'(i), progData)
      `FCSM_CHK("otp busy state", fcsm_pkg::S_OTP_BUSY, state)
      `FCSM_CHK("otp busy flag", 1'b0, wsmReadyFlag)
      i_host.send(nxt[i]);
      `FCSM_CHK("otp ignores writes", fcsm_pkg::S_OTP_BUSY, state)
      `FCSM_CHK("otp still busy", 1'b0, wsmReadyFlag)
      `FCSM_CHK("start pulse ends", 1'b0, progStart)
      wait_ready();
      `FCSM_CHK("otp done state", fcsm_pkg::S_OTP_DONE, state)
      `FCSM_CHK("otp done status", fcsm_pkg::RD_STATUS, readSel)
      i_host.send(nxt[i]);
      `FCSM_CHK("otp done command", exp[i], state)
      if (exp[i] == fcsm_pkg::S_PRG_SETUP) begin
        i_host.send(8'h5A);
        `FCSM_CHK("array after otp kind", 1'b0, otpProg)
        `FCSM_CHK("array after otp data", 8'h5A, progData)
      end
    end
    $display("test otp done");
  endtask

  task automatic t_prog();
    logic [7:0] setup [2] = '{fcsm_pkg::CMD_PROG_SETUP_A,
      fcsm_pkg::CMD_PROG_SETUP_B};
    for (int i = 0; i < 2; i++) begin
      do_reset();
      i_host.send(setup[i]);
      `FCSM_CHK("prog setup ready", 1'b1, wsmReadyFlag)
      i_host.send(8'h3C);
      `FCSM_CHK("prog busy state", fcsm_pkg::S_PRG_BUSY, state)
      `FCSM_CHK("prog busy flag", 1'b0, wsmReadyFlag)
      `FCSM_CHK("array kind", 1'b0, otpProg)
      `FCSM_CHK("prog data", 8'h3C, progData)
      repeat (50) @(posedge ref_clk);
      i_host.send(fcsm_pkg::CMD_SUSPEND);
      `FCSM_CHK("suspend state", fcsm_pkg::S_RS_PS, state)
      `FCSM_CHK("suspended ready", 1'b1, wsmReadyFlag)
      i_host.send(fcsm_pkg::CMD_WBUF_SETUP);
      `FCSM_CHK("suspend buffer setup", fcsm_pkg::S_RA_PS, state)
      i_host.send(fcsm_pkg::CMD_READ_ARRAY);
      `FCSM_CHK("suspend read array", fcsm_pkg::S_RA_PS, state)
      `FCSM_CHK("suspend array sel", fcsm_pkg::RD_ARRAY, readSel)
      i_host.send(fcsm_pkg::CMD_CONFIRM);
      `FCSM_CHK("resume busy", 1'b0, wsmReadyFlag)
      wait_ready();
      `FCSM_CHK("prog done state", fcsm_pkg::S_RS, state)
    end
    $display("test program done");
  endtask

  initial begin
    repeat (3) @(posedge ref_clk);
    t_lock();
    t_otp();
    t_prog();
    summarize();
  end
endmodule
